/* logic/fbod_host.sv */
// Host-side driver for an asynchronous parallel flash: one bus operation per command, none for a refused unprotect.
// Assumes flash pins are synchronous to CLK and that the bench resolves the data wire
// from the three output enables; elevated levels are carried by the *_VID flags.
`timescale 1ns/1ps

module fbod_host
    import fbod_pkg::*;
#(
    parameter int unsigned         PROT_CYC   = fbod_pkg::C_PROTECT,
    parameter int unsigned         UNPROT_CYC = fbod_pkg::C_UNPROT,
    parameter logic [BLK_N-1:0]    REQ_MASK   = {BLK_N{1'b1}}
)
(
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // Command
    input  wire logic                   CMD_VALID,
    input  wire fbod_pkg::fbod_op_e     CMD_OP,
    input  wire logic [19:0]            CMD_ADDR,
    input  wire logic [15:0]            CMD_DATA,
    input  wire logic                   CMD_WIDE,
    input  wire logic                   TEMP_UNPROT,
    output logic                        CMD_READY,
    // Response
    output logic                        RSP_VALID,
    output logic                        RSP_REFUSED,
    output logic [15:0]                 RSP_DATA,
    // Flash control pins
    output logic                        MEM_CE_N,
    output logic                        MEM_CE_VID,
    output logic                        MEM_OE_N,
    output logic                        MEM_OE_VID,
    output logic                        MEM_WE_N,
    output logic                        MEM_RP_N,
    output logic                        MEM_RP_VID,
    output logic                        MEM_WORD,
    // Flash address pins
    output logic [18:0]                 MEM_ADDR,
    output logic                        MEM_SIG_VID,
    // Flash data pins
    output logic [15:0]                 MEM_DQ_O,
    output logic [2:0]                  MEM_DQ_OE,
    input  wire logic [15:0]            MEM_DQ_I
);
    import fbod_pkg::*;

    // ==========================================================
    // Command latch and sequencer
    fbod_state_e      state_r;
    fbod_state_e      state_nxt;
    fbod_op_e         op_r;
    logic [19:0]      addr_r;
    logic [15:0]      data_r;
    logic             wide_r;
    logic [BLK_N-1:0] prot_map_r;
    logic             tmr_done;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;

    wire accept   = CMD_VALID && CMD_READY;
    wire all_prot = &(prot_map_r | ~REQ_MASK);
    wire refuse   = accept && (CMD_OP == OP_UNPROT) && !all_prot;
    wire start    = accept && !refuse;

    // Decode from the command being taken, so the control and address pins set on the take edge already
    // belong to it and not to the previous operation; the data lines from data_r keep the previous data until the next edge
    fbod_op_e         op_c;
    logic [19:0]      addr_c;
    logic             wide_c;
    assign op_c   = start ? CMD_OP : op_r;
    assign addr_c = start ? CMD_ADDR : addr_r;
    assign wide_c = start ? CMD_WIDE : wide_r;

    wire is_rd    = (op_c == OP_READ) || (op_c == OP_SIG) || (op_c == OP_PVER)
                    || (op_c == OP_UVER);
    wire is_pulse = (op_c == OP_WRITE) || (op_c == OP_PROT) || (op_c == OP_UNPROT);
    wire is_ver   = (op_c == OP_PVER) || (op_c == OP_UVER);
    wire is_rst   = (op_c == OP_RESET);

    wire fin_setup = (state_r == S_SETUP) && tmr_done;
    wire fin_act   = (state_r == S_ACT) && tmr_done;
    wire fin_rec   = (state_r == S_REC) && tmr_done;

    assign state_nxt = start     ? S_SETUP :
                       fin_setup ? S_ACT   :
                       fin_act   ? S_REC   :
                       fin_rec   ? S_IDLE  : state_r;

    // Active phase length depends on the operation
    wire [TMR_W-1:0] act_len =
        is_rd                ? TMR_W'(C_ACCESS - 1)   :
        (op_r == OP_WRITE)   ? TMR_W'(C_WE - 1)       :
        (op_r == OP_PROT)    ? TMR_W'(PROT_CYC - 1)   :
        (op_r == OP_UNPROT)  ? TMR_W'(UNPROT_CYC - 1) :
                               TMR_W'(C_RESET - 1);

    assign tmr_load = start || fin_setup || fin_act;
    assign tmr_val  = start ? TMR_W'(C_SETUP - 1) : (fin_setup ? act_len : TMR_W'(C_RECOVER - 1));

    fbod_timer u_timer (
        .clk      (CLK),
        .rst      (RST),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // ==========================================================
    // Pin decode from the next state
    wire nx_on   = (state_nxt == S_SETUP) || (state_nxt == S_ACT);
    wire nx_act  = (state_nxt == S_ACT);
    wire nx_busy = (state_nxt != S_IDLE);

    // Byte mode moves the least address bit onto the top data pin
    wire [18:0] base_addr = wide_c ? addr_c[18:0] : addr_c[19:1];

    wire [18:0] set_m = (is_ver ? M_VSEL : 19'h00000)
                      | ((op_c == OP_UVER) ? M_PVER : 19'h00000)
                      | ((op_c == OP_UNPROT) ? M_UNP_BLK : 19'h00000);
    wire [18:0] clr_m = (is_ver ? M_LOWEST : 19'h00000)
                      | ((op_c == OP_PVER) ? M_PVER : 19'h00000)
                      | ((op_c == OP_SIG) ? M_VSEL : 19'h00000);
    wire [18:0] addr_out = (base_addr & ~clr_m) | set_m;

    // Elevated-level qualifiers stay up through recovery so the strobe rises under them
    wire sig_vid_w = nx_busy && ((op_c == OP_SIG) || (op_c == OP_PROT) || (op_c == OP_UNPROT)
                     || is_ver);
    wire oe_vid_w  = nx_busy && ((op_c == OP_PROT) || (op_c == OP_UNPROT));
    wire ce_vid_w  = nx_busy && (op_c == OP_UNPROT);

    // Chip select leads the strobe and rises on the same edge as it, so the strobe edges set capture
    wire ce_n_w = !(nx_on && !is_rst && (op_c != OP_UNPROT));
    wire oe_n_w = !(nx_act && is_rd);
    wire we_n_w = !(nx_act && is_pulse);
    wire rp_n_w = !(nx_act && is_rst);
    wire rp_vid_w = TEMP_UNPROT && rp_n_w;

    wire drv_data = nx_busy && (op_c == OP_WRITE);
    wire [2:0] dq_oe_w = {wide_c ? drv_data : (nx_busy && !is_rst),
                          wide_c && drv_data,
                          drv_data};
    wire [15:0] dq_o_w = {wide_c ? data_r[15] : addr_c[0], data_r[14:0]};

    // Byte mode upper lines float, so only the low byte is meaningful
    wire [15:0] rd_word = wide_r ? MEM_DQ_I : {8'h00, MEM_DQ_I[7:0]};
    wire        rd_take = fin_act && is_rd;

    // ==========================================================
    // Protection bookkeeping, one flag per block code
    wire [BLK_W-1:0] blk_idx  = addr_out[BLK_LO +: BLK_W];
    wire             prot_end = fin_act && (op_r == OP_PROT);
    wire             unp_end  = fin_act && (op_r == OP_UNPROT);

    genvar gi;
    generate
        for (gi = 0; gi < BLK_N; gi++) begin : g_blk
            always_ff @(posedge CLK) begin
                if (RST) begin
                    prot_map_r[gi] <= 1'b0;
                end else if (prot_end && (blk_idx == BLK_W'(gi))) begin
                    prot_map_r[gi] <= 1'b1;
                end else if (unp_end) begin
                    prot_map_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= S_IDLE;
            op_r    <= OP_READ;
            addr_r  <= 20'h00000;
            data_r  <= 16'h0000;
            wide_r  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (start) begin
                op_r   <= CMD_OP;
                addr_r <= CMD_ADDR;
                data_r <= CMD_DATA;
                wide_r <= CMD_WIDE;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            CMD_READY   <= 1'b0;
            RSP_VALID   <= 1'b0;
            RSP_REFUSED <= 1'b0;
            RSP_DATA    <= RSP_RESET;
        end else begin
            CMD_READY   <= (state_nxt == S_IDLE) && !accept;
            RSP_VALID   <= fin_rec || refuse;
            RSP_REFUSED <= refuse;
            if (rd_take) begin
                RSP_DATA <= rd_word;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            MEM_CE_N    <= 1'b1;
            MEM_CE_VID  <= 1'b0;
            MEM_OE_N    <= 1'b1;
            MEM_OE_VID  <= 1'b0;
            MEM_WE_N    <= 1'b1;
            MEM_RP_N    <= 1'b1;
            MEM_RP_VID  <= 1'b0;
            MEM_WORD    <= 1'b1;
            MEM_ADDR    <= 19'h00000;
            MEM_SIG_VID <= 1'b0;
            MEM_DQ_O    <= 16'h0000;
            MEM_DQ_OE   <= 3'h0;
        end else begin
            MEM_CE_N    <= ce_n_w;
            MEM_CE_VID  <= ce_vid_w;
            MEM_OE_N    <= oe_n_w;
            MEM_OE_VID  <= oe_vid_w;
            MEM_WE_N    <= we_n_w;
            MEM_RP_N    <= rp_n_w;
            MEM_RP_VID  <= rp_vid_w;
            MEM_WORD    <= wide_c;
            MEM_ADDR    <= addr_out;
            MEM_SIG_VID <= sig_vid_w;
            MEM_DQ_O    <= dq_o_w;
            MEM_DQ_OE   <= dq_oe_w;
        end
    end

endmodule : fbod_host

/* logic/fbod_pkg.sv */
// Constants and types for the host-side bus driver of an asynchronous parallel flash.
// Assumes a 200 MHz system clock and a flash whose pins are modelled digitally:
// each pin that can be raised to the identification level has a separate qualifier flag.

package fbod_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_PS         = 5000;
    localparam int unsigned T_SETUP_NS     = 10;
    localparam int unsigned T_ACCESS_NS    = 100;
    localparam int unsigned T_WE_PULSE_NS  = 50;
    localparam int unsigned T_RECOVER_NS   = 20;
    localparam int unsigned T_RESET_NS     = 500;
    localparam int unsigned T_PROTECT_US   = 100;
    localparam int unsigned T_UNPROTECT_MS = 10;

    // Least times round up to whole cycles
    localparam int unsigned C_SETUP   = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned C_ACCESS  = (T_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned C_WE      = (T_WE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned C_RECOVER = (T_RECOVER_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned C_RESET   = (T_RESET_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned C_PROTECT = (T_PROTECT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    // Cycles per millisecond first, so the product stays inside 32 bits
    localparam int unsigned C_UNPROT  = T_UNPROTECT_MS * ((1000000000 + CLK_PS - 1) / CLK_PS);

    localparam int unsigned TMR_W = 21;

    // ==========================================================
    // Address field positions and masks
    localparam int unsigned ADDR_W    = 19;
    localparam int unsigned BLK_LO    = 12;
    localparam int unsigned BLK_W     = 7;
    localparam int unsigned BLK_N     = 128;
    localparam logic [18:0] M_LOWEST  = 19'h00001;
    localparam logic [18:0] M_VSEL    = 19'h00002;
    localparam logic [18:0] M_PVER    = 19'h00040;
    localparam logic [18:0] M_UNP_BLK = 19'h09000;

    localparam logic [15:0] RSP_RESET = 16'h0000;

    // ==========================================================
    // Operations and states
    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_WRITE  = 3'h1,
        OP_SIG    = 3'h2,
        OP_PROT   = 3'h3,
        OP_UNPROT = 3'h4,
        OP_PVER   = 3'h5,
        OP_UVER   = 3'h6,
        OP_RESET  = 3'h7
    } fbod_op_e;

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SETUP = 4'b0010,
        S_ACT   = 4'b0100,
        S_REC   = 4'b1000
    } fbod_state_e;

endpackage : fbod_pkg

/* logic/fbod_timer.sv */
// Down counter that times each phase of a flash bus cycle.
// Assumes the caller loads the phase length minus one on the edge that enters the phase.
`timescale 1ns/1ps

module fbod_timer
    import fbod_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] load_val,
    // Status
    output logic                  done
);

    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;

    assign cnt_nxt = load ? load_val : ((cnt_r == '0) ? cnt_r : cnt_r - 1'b1);
    assign done    = (cnt_r == '0);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : fbod_timer

/* tb/fbod_flash_model.sv */
// Behavioural flash on the host's pins: array, signature, block protection.
// Assumes clean pin edges from a registered host and a bench-resolved data wire.
`timescale 1ns/1ps

module fbod_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h96  // Arbitrary value
)
(
    // Control pins, elevated levels as separate flags
    input  wire logic        ce_n, ce_vid, oe_n, oe_vid, we_n,
    input  wire logic        rp_n, rp_vid, word, sig_vid,
    // Address and data
    input  wire logic [18:0] addr,
    input  wire logic [15:0] dq,
    output logic      [15:0] q,
    output logic      [15:0] q_en
);
    logic [15:0]  mem [256];
    logic [127:0] prot_r = '0;
    logic [18:0]  la_r;
    logic [7:0]   li_r, ridx;
    logic         act_r = 1'b0;

    // ==========================================================
    // Read side
    assign ridx = {addr[6:0], word ? 1'b0 : dq[15]};
    assign q = !sig_vid ? mem[ridx] : !addr[1] ?
               {8'h00, addr[0] ? DEV_CODE : MFR_CODE} : {15'h0, prot_r[addr[18:12]]};
    // Level-driven only, so idle time never drops the last data
    assign q_en = (!ce_n && !oe_n && rp_n) ? (word ? 16'hffff : 16'h00ff) : 16'h0;

    // ==========================================================
    // Write side
    always @(negedge we_n, negedge ce_n)
        if (!we_n && (!ce_n || ce_vid) && oe_n && rp_n) begin
            la_r = addr;
            li_r = ridx;
            act_r = 1'b1;
        end
    always @(negedge rp_n) act_r = 1'b0;
    always @(posedge we_n, posedge ce_n)
        if (act_r) begin
            act_r = 1'b0;
            if (ce_vid && oe_vid && sig_vid && la_r[12] && la_r[15])
                prot_r = '0;
            else if (oe_vid && sig_vid)
                prot_r[la_r[18:12]] = 1'b1;
            else if (!prot_r[la_r[18:12]] || rp_vid)
                mem[li_r] = word ? dq : {mem[li_r][15:8], dq[7:0]};
        end
endmodule : fbod_flash_model

/* tb/fbod_host_chk.sv */
// Timing checks on the flash host's ports.
// Assumes the package counts for setup, access and recovery.
`timescale 1ns/1ps

module fbod_host_chk
    import fbod_pkg::*;
(
    // Clock, reset, command
    input wire logic               CLK,
    input wire logic               RST,
    input wire logic               CMD_VALID,
    input wire fbod_pkg::fbod_op_e CMD_OP,
    input wire logic               CMD_READY,
    input wire logic               RSP_VALID,
    // Flash pins
    input wire logic               MEM_CE_N,
    input wire logic               MEM_CE_VID,
    input wire logic               MEM_OE_N,
    input wire logic               MEM_OE_VID,
    input wire logic               MEM_WE_N,
    input wire logic               MEM_RP_N,
    input wire logic               MEM_WORD,
    input wire logic [18:0]        MEM_ADDR,
    input wire logic               MEM_SIG_VID,
    input wire logic [15:0]        MEM_DQ_O,
    input wire logic [2:0]         MEM_DQ_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // ==========================================================
    // Assertions
    oe_gate_a: assert property (
        !MEM_WE_N |-> MEM_OE_N && (!MEM_CE_N || MEM_CE_VID)) else $error("write with gate low");
    no_fight_a: assert property (
        !MEM_OE_N |-> MEM_DQ_OE[1:0] == 2'b00 && !MEM_CE_N && (!MEM_WORD || !MEM_DQ_OE[2]))
        else $error("host drives data during read");
    read_setup_a: assert property (
        $fell(MEM_OE_N) |-> $past(MEM_CE_N, 2) == 1'b0 && MEM_WE_N) else $error("read setup");
    addr_hold_a: assert property (
        !MEM_WE_N && $past(!MEM_WE_N) |-> $stable(MEM_ADDR)) else $error("address moved");
    data_hold_a: assert property (
        $rose(MEM_WE_N) && !MEM_OE_VID |-> MEM_DQ_OE[0] && $stable(MEM_DQ_O))
        else $error("data not held at strobe rise");
    prot_lvl_a: assert property (
        $fell(MEM_WE_N) && MEM_OE_VID && !MEM_CE_VID |-> MEM_SIG_VID && !MEM_CE_N)
        else $error("protect levels");
    unprot_lvl_a: assert property (
        $fell(MEM_WE_N) && MEM_CE_VID |-> MEM_OE_VID && MEM_SIG_VID && MEM_ADDR[12]
        && MEM_ADDR[15]) else $error("unprotect levels");
    byte_pin_a: assert property (
        !MEM_WORD && !MEM_CE_N |-> MEM_DQ_OE[2] && !MEM_DQ_OE[1]) else $error("byte mode pins");
    reset_pulse_a: assert property (
        $fell(MEM_RP_N) |-> MEM_CE_N ##1 (!MEM_RP_N && MEM_CE_N) [*8]) else $error("reset pulse");
    read_lat_a: assert property (
        CMD_VALID && CMD_READY && CMD_OP == OP_READ |-> ##27 RSP_VALID) else $error("read latency");
    take_busy_a: assert property (
        CMD_VALID && CMD_READY |=> !CMD_READY) else $error("ready after take");

    cover property ($fell(MEM_WE_N) && MEM_CE_VID);
    cover property ($fell(MEM_OE_N) && MEM_SIG_VID);
    cover property ($fell(MEM_RP_N));
endmodule : fbod_host_chk

/* tb/testbench.sv */
// Self-checking bench: flash host driving a behavioural flash.
// Assumes short protect counts and two blocks required before unprotect.
`timescale 1ns/1ps

module testbench;
    import fbod_pkg::*;
    localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEV = 8'h96; // Arbitrary value
    logic clk, rst, vld, wide, tunp, rdy, rv, rref, got_ref;
    logic ce_n, ce_v, oe_n, oe_v, we_n, rp_n, rp_v, word, sig_v;
    fbod_op_e op;
    logic [19:0] adr;
    logic [18:0] maddr;
    logic [15:0] wdat, rdat, rsp, dq_o, dq_i, fq, fen, flt_r, hm;
    logic [2:0]  dq_oe;
    int          fail_count, tests_run;

    // ==========================================================
    // Wire resolution; floating lines toggle so they never pass for data
    assign hm = {dq_oe[2], {7{dq_oe[1]}}, {8{dq_oe[0]}}};
    assign dq_i = (hm & dq_o) | (~hm & fen & fq) | (~hm & ~fen & flt_r);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) flt_r <= ~flt_r;

    fbod_host #(.PROT_CYC(4), .UNPROT_CYC(4), .REQ_MASK(128'h3)) DUT (
        .CLK(clk), .RST(rst), .CMD_VALID(vld), .CMD_OP(op), .CMD_ADDR(adr), .CMD_DATA(wdat),
        .CMD_WIDE(wide), .TEMP_UNPROT(tunp), .CMD_READY(rdy), .RSP_VALID(rv),
        .RSP_REFUSED(rref), .RSP_DATA(rsp), .MEM_CE_N(ce_n), .MEM_CE_VID(ce_v),
        .MEM_OE_N(oe_n), .MEM_OE_VID(oe_v), .MEM_WE_N(we_n), .MEM_RP_N(rp_n),
        .MEM_RP_VID(rp_v), .MEM_WORD(word), .MEM_ADDR(maddr), .MEM_SIG_VID(sig_v),
        .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_DQ_I(dq_i));
    fbod_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (
        .ce_n(ce_n), .ce_vid(ce_v), .oe_n(oe_n), .oe_vid(oe_v), .we_n(we_n), .rp_n(rp_n),
        .rp_vid(rp_v), .word(word), .sig_vid(sig_v), .addr(maddr), .dq(dq_i), .q(fq),
        .q_en(fen));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input fbod_op_e o, input logic [19:0] a, input logic [15:0] d,
                       input logic w);
        int n = 0;
        while (rdy !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (rdy !== 1'b1) begin
            fail_count++;
            $display("MISMATCH t=%0t host never ready", $time);
        end
        op = o;
        adr = a;
        wdat = d;
        wide = w;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        n = 0;
        while (rv !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (rv !== 1'b1) begin
            fail_count++;
            $display("MISMATCH t=%0t no response", $time);
        end
        got_ref = rref;
        rdat = rsp;
    endtask : cmd

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // ==========================================================
    // Scenarios
    task automatic t_wr_rd;
        cmd(OP_WRITE, 20'h00005, 16'hbeef, 1'b1);
        cmd(OP_READ, 20'h00005, 16'h0, 1'b1);
        chk(rdat, 16'hbeef);
        cmd(OP_WRITE, 20'h00003, 16'h00c4, 1'b0);
        cmd(OP_READ, 20'h00003, 16'h0, 1'b0);
        chk(rdat, 16'h00c4);
    endtask : t_wr_rd

    task automatic t_sig;
        cmd(OP_SIG, 20'h00000, 16'h0, 1'b1);
        chk(rdat, {8'h00, MFR});
        cmd(OP_SIG, 20'h7fffd, 16'h0, 1'b1);
        chk(rdat, {8'h00, DEV});
    endtask : t_sig

    task automatic t_prot;
        cmd(OP_UNPROT, 20'h0, 16'h0, 1'b1);
        chk({15'h0, got_ref}, 16'h1);
        cmd(OP_PROT, 20'h00000, 16'h0, 1'b1);
        cmd(OP_PVER, 20'h00000, 16'h0, 1'b1);
        chk(rdat, 16'h0001);
        cmd(OP_PVER, 20'h02000, 16'h0, 1'b1);
        chk(rdat, 16'h0000);
        cmd(OP_WRITE, 20'h00005, 16'h1234, 1'b1);
        cmd(OP_READ, 20'h00005, 16'h0, 1'b1);
        chk(rdat, 16'hbeef);
        tunp = 1'b1;
        cmd(OP_WRITE, 20'h00005, 16'h1234, 1'b1);
        tunp = 1'b0;
        cmd(OP_READ, 20'h00005, 16'h0, 1'b1);
        chk(rdat, 16'h1234);
        cmd(OP_WRITE, 20'h00005, 16'h5678, 1'b1);
        cmd(OP_READ, 20'h00005, 16'h0, 1'b1);
        chk(rdat, 16'h1234);
        cmd(OP_PROT, 20'h01000, 16'h0, 1'b1);
        cmd(OP_UNPROT, 20'h0, 16'h0, 1'b1);
        chk({15'h0, got_ref}, 16'h0);
        cmd(OP_UVER, 20'h00000, 16'h0, 1'b1);
        chk(rdat, 16'h0000);
        cmd(OP_UVER, 20'h01000, 16'h0, 1'b1);
        chk(rdat, 16'h0000);
    endtask : t_prot

    task automatic t_rst;
        cmd(OP_RESET, 20'h0, 16'h0, 1'b1);
        chk({15'h0, got_ref}, 16'h0);
        cmd(OP_READ, 20'h00005, 16'h0, 1'b1);
        chk(rdat, 16'h1234);
    endtask : t_rst

    initial begin
        rst = 1'b1;
        vld = 1'b0;
        op = OP_READ;
        adr = '0;
        wdat = '0;
        wide = 1'b1;
        tunp = 1'b0;
        flt_r = 16'h5a5a;
        fail_count = 0;
        tests_run = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_wr_rd;
        t_sig;
        t_prot;
        t_rst;
        conclude;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude;
    end
endmodule : testbench

bind fbod_host fbod_host_chk u_chk (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .MEM_CE_N(MEM_CE_N),
    .MEM_CE_VID(MEM_CE_VID), .MEM_OE_N(MEM_OE_N), .MEM_OE_VID(MEM_OE_VID),
    .MEM_WE_N(MEM_WE_N), .MEM_RP_N(MEM_RP_N), .MEM_WORD(MEM_WORD), .MEM_ADDR(MEM_ADDR),
    .MEM_SIG_VID(MEM_SIG_VID), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE));
